/* rtl/dcd_top.sv */
// top of the two-channel dac control: registers, standby handling, channel gating
//
// How it works
// - two 8-bit value registers, converted and driven while that channel is enabled
// - value registers clear to zero on reset and in standby
// - control register becomes 0x1f on reset and in standby
// - control bit 7 enables channel 1 conversion and output
// - control bit 6 enables channel 0 conversion and output
// - control bit 5 set makes either enable convert both channels
// - a pin drives only when its own output enable is set
// - both enables clear means no conversion in either channel
// - control bits 4..0 ignore writes and read as one
// - standby control is 0xfe on reset and hardware standby, kept in software standby
// - standby control bits 7..1 ignore writes and read as one
// - standby bit 0 keeps outputs alive during software standby
// - with keep set, software standby leaves every register untouched
// - a changing write to a value register restarts its conversion
// - output level is value over 256 times reference
// - setting an output enable starts conversion of an idle channel and drives the pin at once; the result follows after conversion time
// - output keeps the old result until a changed value finishes converting or enable clears; clearing releases the pin
// - each conversion completes within ten microseconds
`timescale 1ns/1ns
module dcd_top #(
    parameter int CONV_CYCLES = dcd_pkg::CONV_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic       hw_standby,
    input  wire logic       sw_standby,
    output logic [7:0]      reg_rdata,
    output logic [7:0]      analog_out_chan0,
    output logic            analog_out_chan0_oe,
    output logic            analog_out_chan0_valid,
    output logic [7:0]      analog_out_chan1,
    output logic            analog_out_chan1_oe,
    output logic            analog_out_chan1_valid
);

    // refuse a conversion time beyond the guaranteed bound
    if (CONV_CYCLES < 1 || CONV_CYCLES > dcd_pkg::CONV_CYCLES) begin : g_bad_cycles
        $error("dcd_top: CONV_CYCLES must lie in 1..documented bound");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] hw_sync;
        logic [1:0] sw_sync;
        logic [7:0] chan0_value;
        logic [7:0] chan1_value;
        logic       chan1_output_enable;
        logic       chan0_output_enable;
        logic       shared_conversion_select;
        logic       standby_output_keep;
        logic [7:0] rdata;
        logic [1:0] restart;
    } dcd_regs_t;

    dcd_regs_t r_q;
    dcd_regs_t r_d;

    logic       hw_stby;
    logic       sw_stby;
    logic       stby_clear;
    logic       conv0;
    logic       conv1;
    logic       drive0;
    logic       drive1;
    dcd_pkg::dcd_pin_t pin0;
    dcd_pkg::dcd_pin_t pin1;

    // assembled read views of the mixed registers
    function automatic logic [7:0] control_view(input dcd_regs_t r);
        control_view = dcd_pkg::CONTROL_RSVD_ONES;
        control_view[dcd_pkg::BIT_CHAN1_OE]    = r.chan1_output_enable;
        control_view[dcd_pkg::BIT_CHAN0_OE]    = r.chan0_output_enable;
        control_view[dcd_pkg::BIT_SHARED_CONV] = r.shared_conversion_select;
    endfunction : control_view

    function automatic logic [7:0] standby_view(input dcd_regs_t r);
        standby_view = dcd_pkg::STANDBY_RSVD_ONES;
        standby_view[dcd_pkg::BIT_STANDBY_KEEP] = r.standby_output_keep;
    endfunction : standby_view

    // ------------------------------------------------------------
    // standby decode after synchronisers
    // ------------------------------------------------------------
    assign hw_stby    = r_q.hw_sync[1];
    assign sw_stby    = r_q.sw_sync[1];
    // software standby with keep set retains everything
    assign stby_clear = hw_stby || (sw_stby && !r_q.standby_output_keep);

    // ------------------------------------------------------------
    // conversion gating and pin drive
    // ------------------------------------------------------------
    always_comb begin
        conv0  = r_q.chan0_output_enable ||
                 (r_q.shared_conversion_select && r_q.chan1_output_enable);
        conv1  = r_q.chan1_output_enable ||
                 (r_q.shared_conversion_select && r_q.chan0_output_enable);
        drive0 = r_q.chan0_output_enable;
        drive1 = r_q.chan1_output_enable;
    end

    // ------------------------------------------------------------
    // register file next state
    // ------------------------------------------------------------
    always_comb begin
        r_d         = r_q;
        r_d.hw_sync = {r_q.hw_sync[0], hw_standby};
        r_d.sw_sync = {r_q.sw_sync[0], sw_standby};
        r_d.restart = 2'b00;
        r_d.rdata   = 8'h00;
        // writes; a changed value flags a restart (idle channels just store)
        if (reg_wr) begin
            if (reg_addr == dcd_pkg::OFS_CHAN0_VALUE) begin
                r_d.chan0_value = reg_wdata;
                r_d.restart[0]  = (reg_wdata != r_q.chan0_value);
            end else if (reg_addr == dcd_pkg::OFS_CHAN1_VALUE) begin
                r_d.chan1_value = reg_wdata;
                r_d.restart[1]  = (reg_wdata != r_q.chan1_value);
            end else if (reg_addr == dcd_pkg::OFS_CONTROL) begin
                r_d.chan1_output_enable      = reg_wdata[dcd_pkg::BIT_CHAN1_OE];
                r_d.chan0_output_enable      = reg_wdata[dcd_pkg::BIT_CHAN0_OE];
                r_d.shared_conversion_select = reg_wdata[dcd_pkg::BIT_SHARED_CONV];
            end else begin
                r_d.standby_output_keep = reg_wdata[dcd_pkg::BIT_STANDBY_KEEP];
            end
        end
        // reads answer in the next cycle
        if (reg_rd) begin
            if (reg_addr == dcd_pkg::OFS_CHAN0_VALUE) begin
                r_d.rdata = r_q.chan0_value;
            end else if (reg_addr == dcd_pkg::OFS_CHAN1_VALUE) begin
                r_d.rdata = r_q.chan1_value;
            end else if (reg_addr == dcd_pkg::OFS_CONTROL) begin
                r_d.rdata = control_view(r_q);
            end else begin
                r_d.rdata = standby_view(r_q);
            end
        end
        // standby clears data and control; hardware standby also standby control
        if (stby_clear) begin
            r_d.chan0_value              = dcd_pkg::RST_CHAN_VALUE;
            r_d.chan1_value              = dcd_pkg::RST_CHAN_VALUE;
            r_d.chan1_output_enable      = dcd_pkg::RST_CONTROL[dcd_pkg::BIT_CHAN1_OE];
            r_d.chan0_output_enable      = dcd_pkg::RST_CONTROL[dcd_pkg::BIT_CHAN0_OE];
            r_d.shared_conversion_select = dcd_pkg::RST_CONTROL[dcd_pkg::BIT_SHARED_CONV];
            r_d.restart                  = 2'b00;
        end
        if (hw_stby) begin
            r_d.standby_output_keep =
                dcd_pkg::RST_STANDBY_CONTROL[dcd_pkg::BIT_STANDBY_KEEP];
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q                          <= '0;
            r_q.chan0_value              <= dcd_pkg::RST_CHAN_VALUE;
            r_q.chan1_value              <= dcd_pkg::RST_CHAN_VALUE;
            r_q.chan1_output_enable      <= dcd_pkg::RST_CONTROL[dcd_pkg::BIT_CHAN1_OE];
            r_q.chan0_output_enable      <= dcd_pkg::RST_CONTROL[dcd_pkg::BIT_CHAN0_OE];
            r_q.shared_conversion_select <= dcd_pkg::RST_CONTROL[dcd_pkg::BIT_SHARED_CONV];
            r_q.standby_output_keep      <=
                dcd_pkg::RST_STANDBY_CONTROL[dcd_pkg::BIT_STANDBY_KEEP];
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // channel sequencers
    // ------------------------------------------------------------
    dcd_channel #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_chan0 (
        .clk        (clk),
        .arst_n     (arst_n),
        .convert_en (conv0),
        .drive_en   (drive0),
        .restart    (r_q.restart[0]),
        .value      (r_q.chan0_value),
        .pin        (pin0)
    );

    dcd_channel #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_chan1 (
        .clk        (clk),
        .arst_n     (arst_n),
        .convert_en (conv1),
        .drive_en   (drive1),
        .restart    (r_q.restart[1]),
        .value      (r_q.chan1_value),
        .pin        (pin1)
    );

    // outputs straight from flip-flops
    assign reg_rdata              = r_q.rdata;
    assign analog_out_chan0       = pin0.level;
    assign analog_out_chan0_oe    = pin0.oe;
    assign analog_out_chan0_valid = pin0.valid;
    assign analog_out_chan1       = pin1.level;
    assign analog_out_chan1_oe    = pin1.oe;
    assign analog_out_chan1_valid = pin1.valid;

endmodule : dcd_top

/* shared/dcd_pkg.sv */
// package: register map, reset values, field positions and timing for the two-channel dac control
package dcd_pkg;

    // ------------------------------------------------------------
    // register offsets (plain port, byte-wide registers)
    // ------------------------------------------------------------
    localparam logic [1:0] OFS_CHAN0_VALUE      = 2'h0;
    localparam logic [1:0] OFS_CHAN1_VALUE      = 2'h1;
    localparam logic [1:0] OFS_CONTROL          = 2'h2;
    localparam logic [1:0] OFS_STANDBY_CONTROL  = 2'h3;

    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CHAN_VALUE       = 8'h00;
    localparam logic [7:0] RST_CONTROL          = 8'h1f;
    localparam logic [7:0] RST_STANDBY_CONTROL  = 8'hfe;
    localparam logic [7:0] CONTROL_RSVD_ONES    = 8'h1f;
    localparam logic [7:0] STANDBY_RSVD_ONES    = 8'hfe;
    localparam int         BIT_CHAN1_OE         = 7;
    localparam int         BIT_CHAN0_OE         = 6;
    localparam int         BIT_SHARED_CONV      = 5;
    localparam int         BIT_STANDBY_KEEP     = 0;

    // ------------------------------------------------------------
    // timing: longest conversion time rounds down to cycles
    // ------------------------------------------------------------
    localparam int         CLK_HZ               = 25_000_000;
    localparam int         CONV_TIME_NS         = 10_000;
    localparam int         CONV_CYCLES          = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int         CNT_W                = 9;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DCD_IDLE    = 2'b00,
        DCD_CONVERT = 2'b01,
        DCD_HOLD    = 2'b11
    } dcd_chan_state_t;

    // one channel's visible pin state
    typedef struct packed {
        logic [7:0] level;
        logic       oe;
        logic       valid;
    } dcd_pin_t;

endpackage : dcd_pkg

/* rtl/dcd_channel.sv */
// one dac channel: conversion sequencer with settle timer and output hold
`timescale 1ns/1ns
module dcd_channel #(
    parameter int CONV_CYCLES = dcd_pkg::CONV_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 convert_en,
    input  wire logic                 drive_en,
    input  wire logic                 restart,
    input  wire logic [7:0]           value,
    output dcd_pkg::dcd_pin_t         pin
);

    // refuse a conversion time that the counter cannot hold
    if (CONV_CYCLES < 1 || CONV_CYCLES > (1 << dcd_pkg::CNT_W) - 1) begin : g_bad_cycles
        $error("dcd_channel: CONV_CYCLES out of range");
    end

    typedef struct packed {
        dcd_pkg::dcd_chan_state_t st;
        logic [dcd_pkg::CNT_W-1:0] cnt;
        dcd_pkg::dcd_pin_t         pin;
    } dcd_ch_t;

    dcd_ch_t s_q;
    dcd_ch_t s_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.pin.oe     = drive_en;
        // a released pin never shows a result, even mid-conversion
        if (!drive_en) begin
            s_d.pin.level = 8'h00;
            s_d.pin.valid = 1'b0;
        end
        case (s_q.st)
            dcd_pkg::DCD_IDLE: begin
                if (convert_en) begin
                    s_d.st  = dcd_pkg::DCD_CONVERT;
                    s_d.cnt = dcd_pkg::CNT_W'(CONV_CYCLES - 1);
                end
                s_d.pin.valid = 1'b0;
            end
            dcd_pkg::DCD_CONVERT: begin
                if (!convert_en) begin
                    s_d.st = dcd_pkg::DCD_IDLE;
                end else if (restart) begin
                    s_d.cnt = dcd_pkg::CNT_W'(CONV_CYCLES - 1);
                end else if (s_q.cnt == '0) begin
                    s_d.st        = dcd_pkg::DCD_HOLD;
                    s_d.pin.valid = drive_en;
                    s_d.pin.level = drive_en ? value : 8'h00;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
            dcd_pkg::DCD_HOLD: begin
                if (!convert_en) begin
                    s_d.st        = dcd_pkg::DCD_IDLE;
                    s_d.pin.valid = 1'b0;
                end else if (restart) begin
                    s_d.st  = dcd_pkg::DCD_CONVERT;
                    s_d.cnt = dcd_pkg::CNT_W'(CONV_CYCLES - 1);
                end else begin
                    s_d.pin.valid = drive_en;
                    s_d.pin.level = drive_en ? value : 8'h00;
                end
            end
            default: begin
                s_d.st = dcd_pkg::DCD_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin = s_q.pin;

endmodule : dcd_channel

/* verif/dcd_load.sv */
// load model: external load on one analog output pin
`timescale 1ns/1ns
module dcd_load #(
    parameter int VREF_MV = 5000
) (
    input  wire logic        clk,
    input  wire logic [7:0]  level,
    input  wire logic        oe,
    input  wire logic        valid,
    output logic      [15:0] pin_mv = 16'h5a5a
);
    // settled voltage while driven with a valid result, a toggling float otherwise
    always_ff @(posedge clk) begin
        if (oe && valid) begin
            pin_mv <= 16'((32'(level) * VREF_MV) / 256);
        end else begin
            pin_mv <= ~pin_mv;
        end
    end
endmodule : dcd_load

/* verif/dcd_monitor.sv */
// assertion checker on the dac control top ports
`timescale 1ns/1ns
module dcd_monitor #(
    parameter int CONV_CYCLES = dcd_pkg::CONV_CYCLES
) (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       hw_standby,
    input wire logic       sw_standby,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] analog_out_chan0,
    input wire logic       analog_out_chan0_oe,
    input wire logic       analog_out_chan0_valid,
    input wire logic       analog_out_chan1_oe,
    input wire logic       analog_out_chan1_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [9:0] wait0_q;
    logic [9:0] wait1_q;
    // cycles spent enabled but not yet settled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait0_q <= 10'h000;
            wait1_q <= 10'h000;
        end else begin
            wait0_q <= (analog_out_chan0_oe && !analog_out_chan0_valid) ?
                       wait0_q + 10'h001 : 10'h000;
            wait1_q <= (analog_out_chan1_oe && !analog_out_chan1_valid) ?
                       wait1_q + 10'h001 : 10'h000;
        end
    end
    property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
    property p_rsvd_ctrl;
        $past(reg_rd) && $past(reg_addr) == 2'h2 |-> reg_rdata[4:0] == 5'h1f;
    endproperty
    a_rsvd_ctrl: assert property (p_rsvd_ctrl) else $error("control low bits not ones");
    property p_rsvd_stby;
        $past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata[7:1] == 7'h7f;
    endproperty
    a_rsvd_stby: assert property (p_rsvd_stby) else $error("standby high bits not ones");
    property p_oe0_on;
        (!hw_standby && !sw_standby)[*4] ##0 (reg_wr && reg_addr == 2'h2 && reg_wdata[6])
            |-> ##[1:2] analog_out_chan0_oe;
    endproperty
    a_oe0_on: assert property (p_oe0_on) else $error("channel 0 pin not enabled");
    property p_oe1_off;
        (!hw_standby && !sw_standby)[*4] ##0 (reg_wr && reg_addr == 2'h2 && !reg_wdata[7])
            |-> ##[1:2] !analog_out_chan1_oe;
    endproperty
    a_oe1_off: assert property (p_oe1_off) else $error("channel 1 pin not released");
    property p_hw_clear; hw_standby[*6] |-> !analog_out_chan0_oe && !analog_out_chan1_oe; endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("pins driven in standby");
    property p_fell0; $fell(analog_out_chan0_oe) |-> ##[0:2] !analog_out_chan0_valid; endproperty
    a_fell0: assert property (p_fell0) else $error("channel 0 valid after release");
    property p_quiet0; !analog_out_chan0_valid |-> analog_out_chan0 == 8'h00; endproperty
    a_quiet0: assert property (p_quiet0) else $error("channel 0 level without result");
    property p_late0; wait0_q <= CONV_CYCLES; endproperty
    a_late0: assert property (p_late0) else $error("channel 0 conversion too slow");
    property p_late1; wait1_q <= CONV_CYCLES; endproperty
    a_late1: assert property (p_late1) else $error("channel 1 conversion too slow");
endmodule : dcd_monitor

bind dcd_top dcd_monitor #(.CONV_CYCLES(CONV_CYCLES)) i_dcd_monitor (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .hw_standby(hw_standby), .sw_standby(sw_standby), .reg_rdata(reg_rdata),
    .analog_out_chan0(analog_out_chan0), .analog_out_chan0_oe(analog_out_chan0_oe),
    .analog_out_chan0_valid(analog_out_chan0_valid), .analog_out_chan1_oe(analog_out_chan1_oe),
    .analog_out_chan1_valid(analog_out_chan1_valid)
);

/* verif/dual_channel_dac_control_test.sv */
// self-checking bench for the two-channel dac control
`timescale 1ns/1ns
module dual_channel_dac_control_test;
    localparam int CC   = 8;
    localparam int VREF = 5000;
    logic        clk        = 1'b0;
    logic        arst_n     = 1'b0;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic        hw_standby = 1'b0;
    logic        sw_standby = 1'b0;
    logic [1:0]  reg_addr   = 2'h0;
    logic [7:0]  reg_wdata  = 8'h00;
    logic [7:0]  reg_rdata, lv0, lv1, v;
    logic        oe0, oe1, ok0, ok1;
    logic [15:0] mv0;
    int          n_errors   = 0;
    int          compares   = 0;
    int          seed       = 32'he4b7;
    int          n;

    initial begin
        forever #20 clk = ~clk;
    end
    dcd_top #(.CONV_CYCLES(CC)) i_dcd_top (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .reg_rdata(reg_rdata), .analog_out_chan0(lv0), .analog_out_chan0_oe(oe0),
        .analog_out_chan0_valid(ok0), .analog_out_chan1(lv1), .analog_out_chan1_oe(oe1),
        .analog_out_chan1_valid(ok1)
    );
    dcd_load #(.VREF_MV(VREF)) i_dcd_load (
        .clk(clk), .level(lv0), .oe(oe0), .valid(ok0), .pin_mv(mv0)
    );

    // ------------------------------------------------------------
    // expectations, bus cycles and checks
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_mv(input logic [7:0] d);
        return 16'((32'(d) * VREF) / 256);
    endfunction : exp_mv
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        compares++;
        if (got !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        chk("reg_rdata", 16'(e), 16'(reg_rdata));
    endtask : rd
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // bounded wait on result 0, result 1 or level 0 reaching v
    task automatic wait_on(input int sel, output int k);
        k = 0;
        while (k < 300 && !(sel == 0 ? ok0 === 1'b1 : sel == 1 ? ok1 === 1'b1 : lv0 === v)) begin
            @(posedge clk);
            k++;
        end
        if (k == 300) begin
            n_errors++;
            close_out();
        end
    endtask : wait_on

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h1f);
        rd(2'h3, 8'hfe);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h00 : 8'($random(seed));
            wr(2'h2, v);
            rd(2'h2, (v & 8'he0) | 8'h1f);
            wr(2'h3, v);
            rd(2'h3, v | 8'hfe);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hff : 8'($random(seed));
            wr(2'h2, 8'h00);
            wr(2'h0, v);
            rd(2'h0, v);
            wr(2'h2, 8'h40);
            wait_on(0, n);
            chk("wait0", 16'h1, 16'(n >= CC && n <= CC + 2));
            chk("level0", 16'(v), 16'(lv0));
            chk("oe1", 16'h0, 16'(oe1));
            @(posedge clk);
            chk("pin0", exp_mv(v), mv0);
        end
        v = v ^ 8'h5a;
        wr(2'h0, v);
        wait_on(2, n);
        chk("restart", 16'h1, 16'(n >= CC && n <= CC + 3));
        wr(2'h2, 8'h00);
        repeat (3) @(posedge clk);
        chk("drive0", 16'h0, 16'({oe0, ok0, lv0}));
        $display("test conversion done");
        wr(2'h1, 8'h3c);
        wr(2'h2, 8'h20);
        repeat (CC + 4) @(posedge clk);
        wr(2'h2, 8'h40);
        wait_on(0, n);
        chk("idle", 16'h1, 16'(n >= CC));
        wr(2'h2, 8'h60);
        repeat (CC + 4) @(posedge clk);
        chk("drive1", 16'h0, 16'({oe1, ok1}));
        wr(2'h2, 8'he0);
        wait_on(1, n);
        chk("shared", 16'h1, 16'(n < CC));
        chk("level1", 16'h3c, 16'(lv1));
        wr(2'h2, 8'h40);
        repeat (CC + 4) @(posedge clk);
        wr(2'h2, 8'hc0);
        wait_on(1, n);
        chk("own", 16'h1, 16'(n >= CC));
        $display("test gating done");
        wr(2'h3, 8'h01);
        sw_standby <= 1'b1;
        repeat (8) @(posedge clk);
        chk("keep", 16'h3, 16'({ok0, ok1}));
        rd(2'h0, v);
        rd(2'h3, 8'hff);
        sw_standby <= 1'b0;
        wr(2'h3, 8'h00);
        sw_standby <= 1'b1;
        repeat (8) @(posedge clk);
        chk("cleared", 16'h0, 16'({oe0, ok0, oe1, ok1}));
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h1f);
        sw_standby <= 1'b0;
        repeat (4) @(posedge clk);
        wr(2'h3, 8'h01);
        hw_standby <= 1'b1;
        repeat (8) @(posedge clk);
        hw_standby <= 1'b0;
        repeat (4) @(posedge clk);
        rd(2'h3, 8'hfe);
        $display("test standby done");
        // reset in mid-run with both channels enabled
        wr(2'h0, 8'h77);
        wr(2'h2, 8'hc0);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("reset_pins", 16'h0, 16'({oe0, ok0, oe1, ok1}));
        arst_n <= 1'b1;
        @(posedge clk);
        rd(2'h2, 8'h1f);
        rd(2'h0, 8'h00);
        $display("test reset done");
        close_out();
    end
endmodule : dual_channel_dac_control_test
